// *** ccp_pkg.sv ***
package ccp_pkg;

  // ==========================================================
  // Bus geometry
  localparam int             ADDR_W          = 8;
  localparam int             DATA_W          = 32;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0]     IDX_VALUE_LOW   = 8'h15;
  localparam logic [7:0]     IDX_VALUE_HIGH  = 8'h16;
  localparam logic [7:0]     IDX_CONTROL     = 8'h17;
  localparam logic [7:0]     IDX_STATUS      = 8'h18;
  localparam logic [7:0]     IDX_MASK        = 8'h19;
  localparam logic [7:0]     ADDR_VALUE_LOW  = {IDX_VALUE_LOW[5:0], 2'b00};
  localparam logic [7:0]     ADDR_VALUE_HIGH = {IDX_VALUE_HIGH[5:0], 2'b00};
  localparam logic [7:0]     ADDR_CONTROL    = {IDX_CONTROL[5:0], 2'b00};
  localparam logic [7:0]     ADDR_STATUS     = {IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0]     ADDR_MASK       = {IDX_MASK[5:0], 2'b00};

  // ==========================================================
  // Field layout and reset values
  localparam int             VALUE_W         = 16;
  localparam int             CTL_W           = 6;
  localparam int             MODE_LSB        = 0;
  localparam int             MODE_MSB        = 3;
  localparam int             DUTY_LSB_POS    = 4;
  localparam int             DUTY_MSB_POS    = 5;
  localparam int             DUTY_W          = 10;
  localparam int             EVENT_BIT       = 0;
  localparam logic [5:0]     CTL_RESET       = 6'h00;
  localparam logic [15:0]    VALUE_RESET     = 16'h0000;
  localparam logic [9:0]     DUTY_RESET      = 10'h000;

  // ==========================================================
  // Mode codes
  localparam logic [3:0]     MODE_OFF        = 4'h0;
  localparam logic [3:0]     MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0]     MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0]     MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0]     MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0]     MODE_CMP_SET    = 4'h8;
  localparam logic [3:0]     MODE_CMP_CLEAR  = 4'h9;
  localparam logic [3:0]     MODE_CMP_SOFT   = 4'hA;
  localparam logic [3:0]     MODE_CMP_SPECIAL = 4'hB;
  localparam logic [1:0]     GROUP_CAPTURE   = 2'h1;
  localparam logic [1:0]     GROUP_COMPARE   = 2'h2;
  localparam logic [1:0]     GROUP_PWM       = 2'h3;

  // ==========================================================
  // Capture prescaler terminal counts
  localparam logic [3:0]     PRESC_ZERO      = 4'h0;
  localparam logic [3:0]     PRESC_ONE       = 4'h1;
  localparam logic [3:0]     PRESC_LAST4     = 4'h3;
  localparam logic [3:0]     PRESC_LAST16    = 4'hF;

endpackage

// *** capture_if.sv ***
`timescale 1ns/100ps
interface capture_if;
  logic [3:0] mode;
  logic       capture_evt;

  modport producer (
    input  mode,
    output capture_evt
  );
  modport consumer (
    output mode,
    input  capture_evt
  );
endinterface

// *** capture_edge_detect.sv ***
`timescale 1ns/100ps
module capture_edge_detect
  import ccp_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_sync_b,
  // Selected pin level, asynchronous
  input  wire logic        pin_in,
  // Link to the control logic
  capture_if.producer      cap
);

  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [3:0] presc_r;
  logic [3:0] presc_nxt;
  logic [3:0] mode_q_r;
  logic       evt_r;
  logic       evt_nxt;
  logic       rise;
  logic       fall;
  logic       prescaled;
  logic [3:0] last_cnt;

  assign rise      = sync2_r & ~prev_r;
  assign fall      = ~sync2_r & prev_r;
  assign prescaled = (cap.mode == MODE_CAP_RISE4) || (cap.mode == MODE_CAP_RISE16);
  assign last_cnt  = (cap.mode == MODE_CAP_RISE16) ? PRESC_LAST16 : PRESC_LAST4;

  // A mode change restarts the prescaler so no stale count leaks in
  assign presc_nxt = (!prescaled || cap.mode != mode_q_r) ? PRESC_ZERO :
                     !rise ? presc_r :
                     (presc_r == last_cnt) ? PRESC_ZERO : presc_r + PRESC_ONE;

  assign evt_nxt   = (cap.mode == MODE_CAP_FALL)  ? fall :
                     (cap.mode == MODE_CAP_RISE)  ? rise :
                     (prescaled && cap.mode == mode_q_r) ? (rise && presc_r == last_cnt) :
                     1'b0;

  // ==========================================================
  // Pin synchroniser and edge history
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ==========================================================
  // Prescaler and event pulse
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      presc_r  <= PRESC_ZERO;
      mode_q_r <= MODE_OFF;
      evt_r    <= 1'b0;
    end else begin
      presc_r  <= presc_nxt;
      mode_q_r <= cap.mode;
      evt_r    <= evt_nxt;
    end
  end

  assign cap.capture_evt = evt_r;

endmodule // capture_edge_detect

// *** capture_compare_pwm_unit.sv ***
// The APB register port was left to the implementer.
`timescale 1ns/100ps
// Behaviour
// - One 16-bit value word serves as capture, compare or duty register according to the mode.
// - The value word is reached as a low byte register and a high byte register.
// - Capture and compare use the first timer count, PWM uses the second timer count.
// - A configuration bit routes the pin function to port B pin two or pin three.
// - Modes 0100, 0101, 0110, 0111 capture on every falling, rising, 4th rising, 16th rising edge.
// - Mode 1000 drives the pin high on a match and sets the event flag.
// - Mode 1001 drives the pin low on a match and sets the event flag.
// - Mode 1010 only sets the event flag on a match and leaves the pin alone.
// - Mode 1011 sets the flag, leaves the pin, resets the first timer and starts an enabled conversion.
module capture_compare_pwm_unit
  import ccp_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timers
  input  wire logic [15:0]       first_timer_count,
  input  wire logic [9:0]        second_timer_count,
  input  wire logic              second_timer_period_start,
  output logic                   first_timer_reset,
  // Converter
  input  wire logic              adc_enabled,
  output logic                   adc_start,
  // Configuration word bit
  input  wire logic              unit_pin_route_select,
  // Pins
  input  wire logic              port_b_pin_two_in,
  output logic                   port_b_pin_two_out,
  output logic                   port_b_pin_two_oe,
  input  wire logic              port_b_pin_three_in,
  output logic                   port_b_pin_three_out,
  output logic                   port_b_pin_three_oe,
  // Interrupt
  output logic                   irq
);

  // ==========================================================
  // Reset release
  logic rst_meta_r;
  logic rst_sync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // ==========================================================
  // Declarations
  logic [CTL_W-1:0]   unit_control_r;
  logic [CTL_W-1:0]   unit_control_nxt;
  logic [VALUE_W-1:0] unit_value_word_r;
  logic [VALUE_W-1:0] unit_value_word_nxt;
  logic               unit_event_flag_r;
  logic               unit_event_flag_nxt;
  logic               mask_r;
  logic               mask_nxt;
  logic               route_meta_r;
  logic               route_r;
  logic               match_q_r;
  logic               out_latch_r;
  logic               out_latch_nxt;
  logic [DUTY_W-1:0]  duty_latch_r;
  logic [DUTY_W-1:0]  duty_latch_nxt;
  logic               pwm_out_r;
  logic               pwm_out_nxt;
  logic               pready_r;
  logic               pslverr_r;
  logic [DATA_W-1:0]  prdata_r;
  logic [DATA_W-1:0]  rdata_mux;
  logic               addr_hit;
  logic               pin2_out_r;
  logic               pin2_oe_r;
  logic               pin3_out_r;
  logic               pin3_oe_r;
  logic               trig_r;
  logic               adc_r;
  logic               irq_r;

  // ==========================================================
  // Mode decode
  logic [3:0]         unit_mode_select;
  logic [1:0]         mode_group;
  logic               is_off;
  logic               is_capture;
  logic               is_compare;
  logic               is_pwm;
  logic               is_special;
  logic [DUTY_W-1:0]  duty_request;

  assign unit_mode_select = unit_control_r[MODE_MSB:MODE_LSB];
  assign mode_group       = unit_mode_select[3:2];
  assign is_off           = (unit_mode_select == MODE_OFF);
  assign is_capture       = (mode_group == GROUP_CAPTURE);
  assign is_compare       = (mode_group == GROUP_COMPARE);
  assign is_pwm           = (mode_group == GROUP_PWM);
  assign is_special       = (unit_mode_select == MODE_CMP_SPECIAL);
  // Low byte holds the eight upper duty bits, control holds the two lower
  assign duty_request     = {unit_value_word_r[7:0],
                             unit_control_r[DUTY_MSB_POS:DUTY_LSB_POS]};

  // ==========================================================
  // APB decode
  logic access_phase;
  logic commit;
  logic wr_commit;
  logic wr_low;
  logic wr_high;
  logic wr_ctl;
  logic wr_status;
  logic wr_mask;

  // One wait state: pready rises the cycle after the access phase starts
  assign access_phase = psel & penable & ~pready_r;
  assign commit       = psel & penable & pready_r;
  assign wr_commit    = commit & pwrite;
  assign wr_low       = wr_commit && (paddr == ADDR_VALUE_LOW);
  assign wr_high      = wr_commit && (paddr == ADDR_VALUE_HIGH);
  assign wr_ctl       = wr_commit && (paddr == ADDR_CONTROL);
  assign wr_status    = wr_commit && (paddr == ADDR_STATUS);
  assign wr_mask      = wr_commit && (paddr == ADDR_MASK);

  always_comb begin
    rdata_mux = '0;
    addr_hit  = 1'b1;
    if (paddr == ADDR_VALUE_LOW) begin
      rdata_mux[7:0] = unit_value_word_r[7:0];
    end else if (paddr == ADDR_VALUE_HIGH) begin
      rdata_mux[7:0] = unit_value_word_r[15:8];
    end else if (paddr == ADDR_CONTROL) begin
      rdata_mux[CTL_W-1:0] = unit_control_r;
    end else if (paddr == ADDR_STATUS) begin
      rdata_mux[EVENT_BIT] = unit_event_flag_r;
    end else if (paddr == ADDR_MASK) begin
      rdata_mux[EVENT_BIT] = mask_r;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // ==========================================================
  // Capture path
  capture_if cap_link ();

  logic selected_pin_in;

  // Route bit is static, so muxing ahead of the synchroniser is safe
  assign selected_pin_in = route_r ? port_b_pin_two_in : port_b_pin_three_in;
  assign cap_link.mode   = unit_mode_select;

  capture_edge_detect u_capture (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .pin_in     (selected_pin_in),
    .cap        (cap_link.producer)
  );

  logic capture_hit;

  assign capture_hit = is_capture & cap_link.capture_evt;

  // ==========================================================
  // Compare path
  logic match_now;
  logic compare_hit;

  // First timer is the time base here; match counted once per entry
  assign match_now   = (first_timer_count == unit_value_word_r);
  assign compare_hit = is_compare & match_now & ~match_q_r;

  // ==========================================================
  // Next values
  assign unit_control_nxt = wr_ctl ? pwdata[CTL_W-1:0] : unit_control_r;

  always_comb begin
    unit_value_word_nxt = unit_value_word_r;
    if (wr_low) begin
      unit_value_word_nxt[7:0] = pwdata[7:0];
    end
    if (wr_high) begin
      unit_value_word_nxt[15:8] = pwdata[7:0];
    end
    // Hardware capture overrides a software write in the same cycle
    if (capture_hit) begin
      unit_value_word_nxt = first_timer_count;
    end
  end

  // Set wins over the write-one clear
  assign unit_event_flag_nxt = capture_hit | compare_hit |
                               (unit_event_flag_r &
                                ~(wr_status & pwdata[EVENT_BIT]));
  assign mask_nxt = wr_mask ? pwdata[EVENT_BIT] : mask_r;

  always_comb begin
    out_latch_nxt = out_latch_r;
    if (is_off) begin
      out_latch_nxt = 1'b0;
    end else if (compare_hit && unit_mode_select == MODE_CMP_SET) begin
      out_latch_nxt = 1'b1;
    end else if (compare_hit && unit_mode_select == MODE_CMP_CLEAR) begin
      out_latch_nxt = 1'b0;
    end
  end

  // Duty is latched at period start so a mid-period write cannot glitch
  always_comb begin
    duty_latch_nxt = duty_latch_r;
    pwm_out_nxt    = pwm_out_r;
    if (!is_pwm) begin
      duty_latch_nxt = DUTY_RESET;
      pwm_out_nxt    = 1'b0;
    end else if (second_timer_period_start) begin
      duty_latch_nxt = duty_request;
      pwm_out_nxt    = (duty_request != DUTY_RESET);
    end else if (second_timer_count == duty_latch_r) begin
      pwm_out_nxt    = 1'b0;
    end
  end

  // ==========================================================
  // Pin drive
  logic drive_en;
  logic drive_val;

  // Soft and special compare keep the latch as it stands on the pin
  assign drive_en  = is_compare | is_pwm;
  assign drive_val = is_pwm ? pwm_out_r : out_latch_r;

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      unit_control_r    <= CTL_RESET;
      unit_value_word_r <= VALUE_RESET;
      unit_event_flag_r <= 1'b0;
      mask_r            <= 1'b0;
    end else begin
      unit_control_r    <= unit_control_nxt;
      unit_value_word_r <= unit_value_word_nxt;
      unit_event_flag_r <= unit_event_flag_nxt;
      mask_r            <= mask_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      route_meta_r <= 1'b0;
      route_r      <= 1'b0;
    end else begin
      route_meta_r <= unit_pin_route_select;
      route_r      <= route_meta_r;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      match_q_r    <= 1'b0;
      out_latch_r  <= 1'b0;
      duty_latch_r <= DUTY_RESET;
      pwm_out_r    <= 1'b0;
    end else begin
      match_q_r    <= match_now & is_compare;
      out_latch_r  <= out_latch_nxt;
      duty_latch_r <= duty_latch_nxt;
      pwm_out_r    <= pwm_out_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= access_phase;
      pslverr_r <= access_phase & ~addr_hit;
      if (access_phase) begin
        prdata_r <= rdata_mux;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin2_out_r <= 1'b0;
      pin2_oe_r  <= 1'b0;
      pin3_out_r <= 1'b0;
      pin3_oe_r  <= 1'b0;
    end else begin
      pin2_out_r <= drive_val;
      pin2_oe_r  <= drive_en & route_r;
      pin3_out_r <= drive_val;
      pin3_oe_r  <= drive_en & ~route_r;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      trig_r <= 1'b0;
      adc_r  <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      trig_r <= is_special & compare_hit;
      adc_r  <= is_special & compare_hit & adc_enabled;
      irq_r  <= unit_event_flag_nxt & mask_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign first_timer_reset    = trig_r;
  assign adc_start            = adc_r;
  assign port_b_pin_two_out   = pin2_out_r;
  assign port_b_pin_two_oe    = pin2_oe_r;
  assign port_b_pin_three_out = pin3_out_r;
  assign port_b_pin_three_oe  = pin3_oe_r;
  assign irq                  = irq_r;

endmodule // capture_compare_pwm_unit

// *** ccp_unit_properties.sv ***
`timescale 1ns/100ps
module ccp_unit_properties
  import ccp_pkg::*;
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst_b,
  // Bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Events and pins
  input wire logic              first_timer_reset,
  input wire logic              adc_enabled,
  input wire logic              adc_start,
  input wire logic              port_b_pin_two_oe,
  input wire logic              port_b_pin_three_oe,
  input wire logic              irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Bus answer
  chk_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("No answer one cycle into access");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("Answer held too long");
  chk_idle_quiet: assert property (!psel |=> !pready)
    else $error("Answer without a request");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("Error flag outside an answer");
  chk_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == '0)
    else $error("Refused read returned data");
  chk_ctl_upper_zero: assert property (pready && !pwrite && paddr == ADDR_CONTROL |-> prdata[DATA_W-1:CTL_W] == '0)
    else $error("Control read shows bits above its width");

  // ==========================================================
  // Special event and pins
  chk_reset_pulse: assert property (first_timer_reset |=> !first_timer_reset)
    else $error("Timer reset pulse too long");
  chk_adc_with_reset: assert property (adc_start |-> first_timer_reset && (adc_enabled || $past(adc_enabled)))
    else $error("Conversion start without special event");
  chk_one_pin_route: assert property (!(port_b_pin_two_oe && port_b_pin_three_oe))
    else $error("Both pins driven");
  chk_release_quiet: assert property ($rose(rst_b) |-> !pready && !irq && !first_timer_reset && !adc_start)
    else $error("Outputs active at reset release");
endmodule // ccp_unit_properties

bind capture_compare_pwm_unit ccp_unit_properties ccp_unit_properties_inst (
  .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .first_timer_reset,
  .adc_enabled, .adc_start, .port_b_pin_two_oe, .port_b_pin_three_oe, .irq
);

// *** pin_partner_model.sv ***
`timescale 1ns/100ps
module pin_partner_model (
  // Clock
  input  wire logic clock,
  // Stimulus from the bench
  input  wire logic ext_drive,
  input  wire logic ext_level,
  input  wire logic aim,
  // Unit pin drive
  input  wire logic two_out,
  input  wire logic two_oe,
  input  wire logic three_out,
  input  wire logic three_oe,
  // Resolved pin levels
  output logic      two_level,
  output logic      three_level
);
  // No pull on the pin, so an undriven line wanders instead of settling
  logic float_r = 1'b0;
  always @(posedge clock) begin
    float_r <= ~float_r;
  end
  assign two_level   = two_oe ? two_out : (ext_drive ? (aim & ext_level) : float_r);
  assign three_level = three_oe ? three_out : (ext_drive ? (!aim & ext_level) : float_r);
endmodule // pin_partner_model

// *** capture_compare_pwm_unit_bench.sv ***
`timescale 1ns/100ps
module capture_compare_pwm_unit_bench;
  import ccp_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_s;
  logic        clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, ftr, adc_st, irq, two_in, two_out, two_oe, three_in, three_out, three_oe;
  logic [15:0] tmr = 16'h0000, ld_val = 16'h0000;
  logic [5:0]  s2 = 6'h00;
  logic        tmr_run = 1'b0, adc_en = 1'b0, route = 1'b1, ext_drive = 1'b0, ext_lvl = 1'b0, aim = 1'b1;
  int          n_ftr = 0, n_adc = 0, err_count = 0, check_count = 0, ones;
  logic [31:0] q;
  logic        e;
  row_s        rows [6] = '{
    '{ADDR_VALUE_LOW,  32'h0000_01A5, 32'h0000_00A5, 1'b0},
    '{ADDR_VALUE_HIGH, 32'h0000_FF3C, 32'h0000_003C, 1'b0},
    '{ADDR_CONTROL,    32'h0000_FF30, 32'h0000_0030, 1'b0},
    '{ADDR_MASK,       32'h0000_0003, 32'h0000_0001, 1'b0},
    '{ADDR_STATUS,     32'h0000_0001, 32'h0000_0000, 1'b0},
    '{8'h68,           32'h0000_00FF, 32'h0000_0000, 1'b1}};

  always #2.5 clock = ~clock;

  // ==========================================================
  // Timer stand-ins: frozen timer shows ld_val so captures are exact
  always @(posedge clock) begin
    if (!tmr_run) tmr <= ld_val;
    else if (ftr) tmr <= 16'h0000;
    else tmr <= tmr + 16'h0001;
    s2 <= s2 + 6'h01;
    n_ftr <= n_ftr + int'(ftr);
    n_adc <= n_adc + int'(adc_st);
  end

  capture_compare_pwm_unit capture_compare_pwm_unit_inst (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_timer_count(tmr),
    .second_timer_count({4'h0, s2}), .second_timer_period_start(s2 == 6'h00), .first_timer_reset(ftr),
    .adc_enabled(adc_en), .adc_start(adc_st), .unit_pin_route_select(route), .port_b_pin_two_in(two_in),
    .port_b_pin_two_out(two_out), .port_b_pin_two_oe(two_oe), .port_b_pin_three_in(three_in),
    .port_b_pin_three_out(three_out), .port_b_pin_three_oe(three_oe), .irq(irq));

  pin_partner_model pin_partner_model_inst (
    .clock(clock), .ext_drive(ext_drive), .ext_level(ext_lvl), .aim(aim), .two_out(two_out), .two_oe(two_oe),
    .three_out(three_out), .three_oe(three_oe), .two_level(two_in), .three_level(three_in));

  // ==========================================================
  // Bus, capture and compare tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    // Request held until the edge that samples pready high, data taken there
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) err_count++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, a, d, rq, re);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rq;
    logic        re;
    apb(1'b0, a, 32'h0000_0000, rq, re);
    chk(rq, exp);
  endtask

  task automatic settle;
    repeat (3) @(negedge clock);
  endtask

  task automatic cap(input logic [3:0] mode, input int n, input logic hit, input logic [15:0] b);
    logic fall;
    fall = (mode == MODE_CAP_FALL);
    tmr_run <= 1'b0;
    ext_drive <= 1'b1;
    wr(ADDR_CONTROL, 32'h0000_0000);
    wr(ADDR_CONTROL, {28'h000_0000, mode});
    wr(ADDR_STATUS, 32'h0000_0001);
    for (int i = 0; i < n; i++) begin
      if (i == n - 1 && n > 1) rdc(ADDR_STATUS, 32'h0000_0000);
      ld_val <= (i == n - 1 && !fall) ? b : 16'h0A0A;
      ext_lvl <= 1'b1;
      repeat (10) @(posedge clock);
      ld_val <= (i == n - 1 && fall) ? b : 16'h0A0A;
      ext_lvl <= 1'b0;
      repeat (10) @(posedge clock);
    end
    rdc(ADDR_STATUS, {31'h0000_0000, hit});
    if (hit) begin
      rdc(ADDR_VALUE_LOW, {24'h00_0000, b[7:0]});
      rdc(ADDR_VALUE_HIGH, {24'h00_0000, b[15:8]});
    end
  endtask

  task automatic cmp(input logic [3:0] mode, input logic exp_out, input logic adc);
    int f0, a0;
    adc_en <= adc;
    tmr_run <= 1'b0;
    ld_val <= 16'h0000;
    wr(ADDR_CONTROL, 32'h0000_0000);
    settle;
    chk({30'h0000_0000, two_oe, two_out}, 32'h0000_0000);
    wr(ADDR_VALUE_LOW, 32'h0000_0030);
    wr(ADDR_VALUE_HIGH, 32'h0000_0000);
    wr(ADDR_CONTROL, {28'h000_0000, mode});
    wr(ADDR_STATUS, 32'h0000_0001);
    f0 = n_ftr;
    a0 = n_adc;
    tmr_run <= 1'b1;
    repeat (56) @(posedge clock);
    tmr_run <= 1'b0;
    settle;
    chk({30'h0000_0000, two_oe, two_out}, {30'h0000_0000, 1'b1, exp_out});
    chk({31'h0000_0000, three_oe}, 32'h0000_0000);
    chk(32'(n_ftr - f0), (mode == MODE_CMP_SPECIAL) ? 32'h0000_0001 : 32'h0000_0000);
    chk(32'(n_adc - a0), (mode == MODE_CMP_SPECIAL && adc) ? 32'h0000_0001 : 32'h0000_0000);
    rdc(ADDR_STATUS, 32'h0000_0001);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(ADDR_CONTROL, 32'h0000_0000);
    rdc(ADDR_VALUE_HIGH, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000, q, e);
      chk(q, rows[i].q);
      chk({31'h0000_0000, e}, {31'h0000_0000, rows[i].e});
    end
    cap(MODE_CAP_FALL, 1, 1'b1, 16'h1234);
    cap(MODE_CAP_RISE, 1, 1'b1, 16'h5678);
    cap(MODE_CAP_RISE4, 4, 1'b1, 16'h9ABC);
    cap(MODE_CAP_RISE16, 16, 1'b1, 16'hDEF0);
    aim <= 1'b0;
    cap(MODE_CAP_RISE, 1, 1'b0, 16'h1111);
    route <= 1'b0;
    cap(MODE_CAP_RISE, 1, 1'b1, 16'h0F0F);
    // Frozen timer equals the captured word, so set-on-match fires on pin three
    ld_val <= 16'h0F0F;
    wr(ADDR_CONTROL, {28'h000_0000, MODE_CMP_SET});
    settle;
    chk({29'h0000_0000, three_out, three_oe, two_oe}, 32'h0000_0006);
    @(posedge clock);
    route <= 1'b1;
    aim <= 1'b1;
    cmp(MODE_CMP_SET, 1'b1, 1'b1);
    cmp(MODE_CMP_CLEAR, 1'b0, 1'b1);
    cmp(MODE_CMP_SOFT, 1'b0, 1'b1);
    cmp(MODE_CMP_SPECIAL, 1'b0, 1'b1);
    cmp(MODE_CMP_SPECIAL, 1'b0, 1'b0);
    wr(ADDR_MASK, 32'h0000_0001);
    settle;
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(ADDR_MASK, 32'h0000_0000);
    settle;
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(ADDR_MASK, 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0001);
    settle;
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    // Duty {04h, 2'b10} is 18 counts of a 64-count period
    wr(ADDR_VALUE_LOW, 32'h0000_0004);
    wr(ADDR_CONTROL, 32'h0000_002C);
    repeat (130) @(posedge clock);
    ones = 0;
    repeat (128) begin
      @(negedge clock);
      ones += int'(two_out);
    end
    chk(32'(ones), 32'h0000_0024);
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    complete_run;
  end
endmodule // capture_compare_pwm_unit_bench
